//--- rtl/nfh_host.sv
/*
  Host controller that drives a NAND flash device through its strobes and
  its shared 8-bit port, one request at a time.
  Assumes the device pins are sampled synchronously to core_clk and that
  the open-drain ready line is pulled up outside.
*/
`timescale 1ns/1ps
`default_nettype none
module nfh_host
  import nfh_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Request side.
  input wire nfh_req_s req,
  input wire logic reqValid,
  input wire logic writeEnable,
  output logic reqReady,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic devReady,
  // Device pins.
  output nfh_pins_s pins,
  input wire logic [7:0] portIn,
  input wire logic readyBusyIn
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD1 = 3'b001,
    ST_ADDR = 3'b010,
    ST_CMD2 = 3'b011,
    ST_DATA_W = 3'b100,
    ST_DATA_R = 3'b101
  } nfh_state_e;

  typedef enum logic [1:0] {
    PH_SETUP = 2'b00,
    PH_LOW = 2'b01,
    PH_HIGH = 2'b10
  } nfh_phase_e;

  function automatic logic [7:0] setupCode(input nfh_op_e op);
    case (op)
      OP_RESET: setupCode = CMD_RESET;
      OP_STATUS: setupCode = CMD_STATUS;
      OP_READ_ID: setupCode = CMD_READ_ID;
      OP_PAGE_READ, OP_COPY_READ: setupCode = CMD_READ_SETUP;
      OP_PAGE_PROG, OP_CACHE_PROG: setupCode = CMD_PROG_SETUP;
      OP_COPY_PROG: setupCode = CMD_COPY_PROG_SETUP;
      OP_BLOCK_ERASE: setupCode = CMD_ERASE_SETUP;
      OP_RAND_IN: setupCode = CMD_RAND_IN;
      OP_RAND_OUT: setupCode = CMD_RAND_OUT_SETUP;
      default: setupCode = CMD_STATUS;
    endcase
  endfunction

  function automatic logic [7:0] execCode(input nfh_op_e op);
    case (op)
      OP_PAGE_READ: execCode = CMD_READ_EXEC;
      OP_COPY_READ: execCode = CMD_COPY_READ_EXEC;
      OP_PAGE_PROG, OP_COPY_PROG: execCode = CMD_PROG_EXEC;
      OP_CACHE_PROG: execCode = CMD_CACHE_EXEC;
      OP_BLOCK_ERASE: execCode = CMD_ERASE_EXEC;
      OP_RAND_OUT: execCode = CMD_RAND_OUT_EXEC;
      default: execCode = CMD_STATUS;
    endcase
  endfunction

  function automatic logic [2:0] addrCycles(input nfh_op_e op);
    case (op)
      OP_PAGE_READ, OP_COPY_READ, OP_PAGE_PROG, OP_CACHE_PROG, OP_COPY_PROG: addrCycles = ADDR_CYCLES_FULL;
      OP_BLOCK_ERASE: addrCycles = ADDR_CYCLES_ROW;
      OP_RAND_IN, OP_RAND_OUT: addrCycles = ADDR_CYCLES_COL;
      OP_READ_ID: addrCycles = ADDR_CYCLES_ID;
      default: addrCycles = ADDR_CYCLES_NONE;
    endcase
  endfunction

  function automatic logic hasExec(input nfh_op_e op);
    case (op)
      OP_PAGE_READ, OP_COPY_READ, OP_PAGE_PROG, OP_CACHE_PROG, OP_COPY_PROG, OP_BLOCK_ERASE, OP_RAND_OUT:
        hasExec = 1'b1;
      default: hasExec = 1'b0;
    endcase
  endfunction

  nfh_state_e state_q, state_d;
  nfh_phase_e phase_q, phase_d;
  nfh_req_s cur_q, cur_d;
  logic [2:0] addrIdx_q, addrIdx_d;
  logic [2:0] addrLeft_q, addrLeft_d;
  logic [1:0] wait_q, wait_d;
  nfh_pins_s pins_q, pins_d;
  logic reqReady_q, reqReady_d;
  logic [7:0] rdData_q, rdData_d;
  logic rdValid_q, rdValid_d;
  logic devReady_q;
  logic [7:0] addrByte;
  logic accept;
  logic opAllowed;

  // Address bytes: two column cycles, then three row cycles, spare bits low.
  always_comb begin
    case (addrIdx_q)
      3'h0: addrByte = cur_q.addr[7:0];
      3'h1: addrByte = {4'h0, cur_q.addr[11:8]};
      3'h2: addrByte = cur_q.addr[19:12];
      3'h3: addrByte = cur_q.addr[27:20];
      3'h4: addrByte = {7'h00, cur_q.addr[28]};
      default: addrByte = 8'h00;
    endcase
  end

  // While busy only reset, status and the status readout go out; program and erase ops need write enable.
  always_comb begin
    case (req.op)
      OP_RESET, OP_STATUS, OP_READ_DATA: opAllowed = 1'b1;
      OP_PAGE_PROG, OP_CACHE_PROG, OP_COPY_PROG, OP_BLOCK_ERASE: opAllowed = devReady_q && writeEnable;
      OP_READ_ID, OP_PAGE_READ, OP_COPY_READ, OP_RAND_IN, OP_RAND_OUT, OP_WRITE_DATA:
        opAllowed = devReady_q;
      default: opAllowed = 1'b0;
    endcase
  end

  assign accept = reqReady_q && reqValid && opAllowed;

  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    cur_d = cur_q;
    addrIdx_d = addrIdx_q;
    addrLeft_d = addrLeft_q;
    wait_d = wait_q;
    pins_d = pins_q;
    reqReady_d = reqReady_q;
    rdData_d = rdData_q;
    rdValid_d = 1'b0;
    pins_d.writeProtN = writeEnable;
    case (state_q)
      ST_IDLE: begin
        pins_d.cmdLatch = 1'b0;
        pins_d.addrLatch = 1'b0;
        pins_d.portOeN = 1'b1;
        if (accept) begin
          cur_d = req;
          reqReady_d = 1'b0;
          phase_d = PH_SETUP;
          wait_d = STROBE_CYC;
          pins_d.chipSelN = 1'b0;
          if (req.op == OP_WRITE_DATA) begin
            state_d = ST_DATA_W;
            pins_d.portOut = req.data;
            pins_d.portOeN = 1'b0;
          end else if (req.op == OP_READ_DATA) begin
            state_d = ST_DATA_R;
          end else begin
            state_d = ST_CMD1;
            pins_d.cmdLatch = 1'b1;
            pins_d.portOut = setupCode(req.op);
            pins_d.portOeN = 1'b0;
          end
          addrIdx_d = (req.op == OP_BLOCK_ERASE) ? 3'h2 : 3'h0;
          addrLeft_d = addrCycles(req.op);
        end
      end
      default: begin
        // Each byte: setup, write or read strobe low, then high to latch.
        if (wait_q != 2'h0) begin
          wait_d = wait_q - 2'h1;
        end else begin
          wait_d = STROBE_CYC;
          case (phase_q)
            PH_SETUP: begin
              phase_d = PH_LOW;
              if (state_q == ST_DATA_R) begin
                pins_d.readStrobeN = 1'b0;
              end else begin
                pins_d.writeStrobeN = 1'b0;
              end
            end
            PH_LOW: begin
              phase_d = PH_HIGH;
              if (state_q == ST_DATA_R) begin
                rdData_d = portIn;
                rdValid_d = 1'b1;
                pins_d.readStrobeN = 1'b1;
              end else begin
                pins_d.writeStrobeN = 1'b1;
              end
            end
            default: begin
              phase_d = PH_SETUP;
              pins_d.cmdLatch = 1'b0;
              pins_d.addrLatch = 1'b0;
              if ((state_q == ST_CMD1 || state_q == ST_ADDR) && addrLeft_q != 3'h0) begin
                state_d = ST_ADDR;
                pins_d.addrLatch = 1'b1;
                pins_d.portOut = addrByte;
                addrIdx_d = addrIdx_q + 3'h1;
                addrLeft_d = addrLeft_q - 3'h1;
              end else if ((state_q == ST_CMD1 || state_q == ST_ADDR) && hasExec(cur_q.op)) begin
                state_d = ST_CMD2;
                pins_d.cmdLatch = 1'b1;
                pins_d.portOut = execCode(cur_q.op);
              end else begin
                state_d = ST_IDLE;
                pins_d.portOeN = 1'b1;
                reqReady_d = 1'b1;
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      phase_q <= PH_SETUP;
      cur_q <= '0;
      addrIdx_q <= 3'h0;
      addrLeft_q <= 3'h0;
      wait_q <= 2'h0;
      pins_q <= '{chipSelN: 1'b1, cmdLatch: 1'b0, addrLatch: 1'b0, writeStrobeN: 1'b1,
                  readStrobeN: 1'b1, writeProtN: 1'b0, portOut: 8'h00, portOeN: 1'b1};
      reqReady_q <= 1'b1;
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
      devReady_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      cur_q <= cur_d;
      addrIdx_q <= addrIdx_d;
      addrLeft_q <= addrLeft_d;
      wait_q <= wait_d;
      pins_q <= pins_d;
      reqReady_q <= reqReady_d;
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
      devReady_q <= readyBusyIn;
    end
  end

  assign pins = pins_q;
  assign reqReady = reqReady_q;
  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign devReady = devReady_q;
endmodule
`default_nettype wire

//--- rtl/nfh_pkg.sv
/*
  Package for the NAND host front end: command codes, address layout,
  pin bundle and request bundle shared by the host controller.
  Assumes a 10 MHz core clock and one device on the shared port.
*/
package nfh_pkg;
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_EXEC = 8'h30;
  localparam logic [7:0] CMD_COPY_READ_EXEC = 8'h35;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_EXEC = 8'h10;
  localparam logic [7:0] CMD_CACHE_EXEC = 8'h15;
  localparam logic [7:0] CMD_COPY_PROG_SETUP = 8'h85;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_EXEC = 8'hd0;
  localparam logic [7:0] CMD_RAND_IN = 8'h85;
  localparam logic [7:0] CMD_RAND_OUT_SETUP = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_EXEC = 8'he0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam int PAGE_BYTES = 2112;
  localparam int MAIN_BYTES = 2048;
  localparam int PAGE_COUNT = 131072;
  localparam int BLOCK_COUNT = 2048;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int COL_BITS = 12;
  localparam int ROW_BITS = 17;
  localparam int ADDR_BITS = 29;
  localparam int BLOCK_LSB = 6;
  localparam logic [2:0] ADDR_CYCLES_FULL = 3'h5;
  localparam logic [2:0] ADDR_CYCLES_ROW = 3'h3;
  localparam logic [2:0] ADDR_CYCLES_NONE = 3'h0;
  localparam logic [2:0] ADDR_CYCLES_COL = 3'h2;
  localparam logic [2:0] ADDR_CYCLES_ID = 3'h1;
  localparam int STROBE_NS = 100;
  localparam int CLK_NS = 100;
  localparam logic [1:0] STROBE_CYC = 2'((STROBE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [3:0] {
    OP_RESET = 4'h0,
    OP_STATUS = 4'h1,
    OP_READ_ID = 4'h2,
    OP_PAGE_READ = 4'h3,
    OP_COPY_READ = 4'h4,
    OP_PAGE_PROG = 4'h5,
    OP_CACHE_PROG = 4'h6,
    OP_COPY_PROG = 4'h7,
    OP_BLOCK_ERASE = 4'h8,
    OP_RAND_IN = 4'h9,
    OP_RAND_OUT = 4'ha,
    OP_WRITE_DATA = 4'hb,
    OP_READ_DATA = 4'hc
  } nfh_op_e;

  typedef struct packed {
    nfh_op_e op;
    logic [ADDR_BITS-1:0] addr;
    logic [7:0] data;
  } nfh_req_s;

  typedef struct packed {
    logic chipSelN;
    logic cmdLatch;
    logic addrLatch;
    logic writeStrobeN;
    logic readStrobeN;
    logic writeProtN;
    logic [7:0] portOut;
    logic portOeN;
  } nfh_pins_s;
endpackage

//--- tb/nfh_dev_model.sv
/*
  Behavioural flash device on the far side of the host's pins.
  Assumes the host pins come straight from the host top module.
*/
`timescale 1ns/1ps
`default_nettype none
module nfh_dev_model
  import nfh_pkg::*;
#(
  parameter int BUSY_NS = 3000
)
(
  // Pins from the host.
  input wire nfh_pins_s pins,
  // Pins to the host.
  output logic [7:0] portIn,
  output logic readyBusyIn
);
  logic [9:0] log[$];
  logic [11:0] col = 12'h000;
  logic [16:0] row = 17'h00000;
  logic [7:0] lastCmd = 8'h00;
  int nAddr = 0;
  logic busy = 1'b0;
  initial portIn = 8'h5a;
  initial readyBusyIn = 1'b1;
  always @(posedge pins.writeStrobeN) begin
    if (!pins.chipSelN && pins.cmdLatch && (!busy || pins.portOut inside {8'hff, 8'h70})) begin
      log.push_back({2'h1, pins.portOut});
      lastCmd = pins.portOut;
      nAddr = (pins.portOut == 8'h60) ? 2 : 0;
      if (pins.portOut inside {8'h30, 8'h35} ||
          (pins.portOut inside {8'h10, 8'h15, 8'hd0} && pins.writeProtN)) begin
        busy = 1'b1;
        readyBusyIn = 1'b0;
        busy <= #(BUSY_NS) 1'b0;
        readyBusyIn <= #(BUSY_NS) 1'b1;
      end
    end else if (!pins.chipSelN && pins.addrLatch && !busy) begin
      log.push_back({2'h2, pins.portOut});
      if (nAddr == 0) col[7:0] = pins.portOut;
      if (nAddr == 1) col[11:8] = pins.portOut[3:0];
      if (nAddr == 2) row[7:0] = pins.portOut;
      if (nAddr == 3) row[15:8] = pins.portOut;
      if (nAddr == 4) row[16] = pins.portOut[0];
      nAddr++;
    end else if (!pins.chipSelN && !busy && !pins.cmdLatch) begin
      log.push_back({2'h0, pins.portOut});
      col++;
    end
  end
  always @(negedge pins.readStrobeN) begin
    if (!pins.chipSelN) begin
      portIn = (lastCmd == 8'h70) ? (busy ? 8'h00 : 8'h40) : col[7:0];
      if (lastCmd != 8'h70) col++;
    end
  end
  always @(posedge pins.readStrobeN) portIn <= #20 ~portIn;
endmodule
`default_nettype wire

//--- tb/nfh_host_chk.sv
/*
  Concurrent checks on the host controller's ports.
  Assumes it is bound into every instance of the host top module.
*/
`timescale 1ns/1ps
`default_nettype none
module nfh_host_chk
  import nfh_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Request side.
  input wire nfh_req_s req,
  input wire logic reqValid,
  input wire logic writeEnable,
  input wire logic reqReady,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire logic devReady,
  // Device pins.
  input wire nfh_pins_s pins,
  input wire logic [7:0] portIn,
  input wire logic readyBusyIn
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_low_then_high;
    !pins.writeStrobeN [*2] ##1 pins.writeStrobeN;
  endsequence
  sequence s_offer;
    reqValid && reqReady;
  endsequence
  property p_strobe; $fell(pins.writeStrobeN) |-> s_low_then_high; endproperty
  property p_latch; !(pins.cmdLatch && pins.addrLatch); endproperty
  property p_drive; !pins.writeStrobeN |-> !pins.chipSelN && !pins.portOeN; endproperty
  property p_hold;
    !pins.writeStrobeN |=> $stable(pins.portOut) && $stable(pins.cmdLatch) && $stable(pins.addrLatch);
  endproperty
  property p_busy;
    s_offer ##0 (!devReady && !(req.op inside {OP_RESET, OP_STATUS, OP_READ_DATA}))
      |=> reqReady && pins.writeStrobeN;
  endproperty
  property p_wp;
    s_offer ##0 (!writeEnable && req.op inside {OP_PAGE_PROG, OP_CACHE_PROG, OP_COPY_PROG, OP_BLOCK_ERASE}) |=> reqReady;
  endproperty
  property p_read; $rose(pins.readStrobeN) |-> rdValid && rdData == $past(portIn); endproperty
  property p_nodrive; !pins.readStrobeN |-> pins.portOeN; endproperty
  property p_status;
    s_offer ##0 req.op == OP_STATUS |=> pins.cmdLatch && pins.portOut == CMD_STATUS && !pins.chipSelN;
  endproperty
  a_strobe: assert property (p_strobe) else $error("write strobe pulse shape wrong");
  a_latch: assert property (p_latch) else $error("both latch strobes high");
  a_drive: assert property (p_drive) else $error("strobe low without select or drive");
  a_hold: assert property (p_hold) else $error("port byte moved under strobe");
  a_busy: assert property (p_busy) else $error("command taken while busy");
  a_wp: assert property (p_wp) else $error("write op taken while protected");
  a_read: assert property (p_read) else $error("read byte not captured");
  a_nodrive: assert property (p_nodrive) else $error("host drives port during read");
  a_status: assert property (p_status) else $error("status code not presented");
endmodule
bind nfh_host nfh_host_chk nfh_host_chk_inst(.core_clk(core_clk), .rst(rst), .req(req), .reqValid(reqValid),
  .writeEnable(writeEnable), .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid), .devReady(devReady),
  .pins(pins), .portIn(portIn), .readyBusyIn(readyBusyIn));
`default_nettype wire

//--- tb/tb_nfh_host.sv
/*
  Self-checking bench for the flash host controller.
  Assumes the behavioural device model answers on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin n_errors++; $display("MISMATCH %0t %s", $time, m); end end
module tb_nfh_host;
  import nfh_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reqValid = 1'b0, writeEnable = 1'b0;
  nfh_req_s req = '0;
  logic reqReady, rdValid, devReady, readyBusyIn;
  logic [7:0] rdData, portIn;
  nfh_pins_s pins;
  int n_errors = 0, compares = 0;
  logic [9:0] expq[$];
  always #50 core_clk = ~core_clk;
  nfh_host nfh_host_inst(.core_clk(core_clk), .rst(rst), .req(req), .reqValid(reqValid),
    .writeEnable(writeEnable), .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid), .devReady(devReady),
    .pins(pins), .portIn(portIn), .readyBusyIn(readyBusyIn));
  nfh_dev_model nfh_dev_model_inst(.pins(pins), .portIn(portIn), .readyBusyIn(readyBusyIn));
  task automatic summarize();
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic issue(nfh_op_e op, logic [28:0] a, logic [7:0] d, bit take);
    int i = 0;
    nfh_dev_model_inst.log.delete();
    @(posedge core_clk);
    req <= '{op, a, d};
    reqValid <= 1'b1;
    do begin @(posedge core_clk); #1; i++; end while (reqReady === 1'b1 && i < 8);
    `CHK(reqReady, 1'(!take), "request acceptance")
    @(posedge core_clk);
    reqValid <= 1'b0;
    i = 0;
    do begin @(posedge core_clk); #1; i++; end while (reqReady !== 1'b1 && i < 100);
    `CHK(reqReady, 1'b1, "transfer did not end")
  endtask
  task automatic wait_dev();
    int i = 0;
    do begin @(posedge core_clk); #1; i++; end while (devReady !== 1'b1 && i < 100);
    `CHK(devReady, 1'b1, "device stays busy")
  endtask
  task automatic seq(nfh_op_e op, logic [28:0] a, logic [7:0] c1, int na, logic [8:0] c2);
    logic [7:0] ab[5] = '{a[7:0], {4'h0, a[11:8]}, a[19:12], a[27:20], {7'h0, a[28]}};
    int s = (na == 3) ? 2 : 0;
    issue(op, a, 8'h00, 1'b1);
    expq = '{{2'h1, c1}};
    for (int i = s; i < s + na; i++) expq.push_back({2'h2, ab[i]});
    if (c2[8]) expq.push_back({2'h1, c2[7:0]});
    `CHK(nfh_dev_model_inst.log.size(), expq.size(), "byte count on port")
    foreach (expq[i]) if (i < nfh_dev_model_inst.log.size())
      `CHK(nfh_dev_model_inst.log[i], expq[i], "port byte")
    if (c2[8] && c2[7:0] != 8'he0) `CHK(devReady, 1'b0, "busy not shown")
  endtask
  task automatic t_single();
    seq(OP_RESET, 29'h0, 8'hff, 0, 9'h000);
    seq(OP_READ_ID, 29'h0, 8'h90, 1, 9'h000);
    seq(OP_STATUS, 29'h0, 8'h70, 0, 9'h000);
    issue(OP_READ_DATA, 29'h0, 8'h00, 1'b1);
    `CHK(rdData, 8'h40, "status byte")
  endtask
  task automatic t_read();
    seq(OP_PAGE_READ, {17'h1abcd, 12'h83f}, 8'h00, 5, 9'h130);
    `CHK(nfh_dev_model_inst.row, 17'h1abcd, "page row")
    wait_dev();
    issue(OP_READ_DATA, 29'h0, 8'h00, 1'b1);
    `CHK(rdData, 8'h3f, "first read byte")
    issue(OP_READ_DATA, 29'h0, 8'h00, 1'b1);
    `CHK(rdData, 8'h40, "next read byte")
  endtask
  task automatic t_erase();
    seq(OP_BLOCK_ERASE, {17'h00040, 12'h0}, 8'h60, 3, 9'h1d0);
    `CHK(nfh_dev_model_inst.row[16:6], 11'h001, "erase block")
    issue(OP_PAGE_READ, 29'h0, 8'h00, 1'b0);
    issue(OP_STATUS, 29'h0, 8'h00, 1'b1);
    issue(OP_READ_DATA, 29'h0, 8'h00, 1'b1);
    `CHK(rdData, 8'h00, "busy status byte")
    wait_dev();
  endtask
  task automatic t_wp();
    @(posedge core_clk);
    writeEnable <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(pins.writeProtN, 1'b0, "protect pin")
    issue(OP_BLOCK_ERASE, 29'h0, 8'h00, 1'b0);
    @(posedge core_clk);
    writeEnable <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic t_prog();
    nfh_op_e ops[6] = '{OP_PAGE_PROG, OP_CACHE_PROG, OP_COPY_PROG, OP_COPY_READ, OP_RAND_IN, OP_RAND_OUT};
    logic [7:0] c1s[6] = '{8'h80, 8'h80, 8'h85, 8'h00, 8'h85, 8'h05};
    int nas[6] = '{5, 5, 5, 5, 2, 2};
    logic [8:0] c2s[6] = '{9'h110, 9'h115, 9'h110, 9'h135, 9'h000, 9'h1e0};
    foreach (ops[i]) begin
      seq(ops[i], {17'h00101, 12'h123}, c1s[i], nas[i], c2s[i]);
      wait_dev();
    end
    issue(OP_READ_DATA, 29'h0, 8'h00, 1'b1);
    `CHK(rdData, 8'h23, "byte at moved column")
    issue(OP_WRITE_DATA, 29'h0, 8'ha5, 1'b1);
    `CHK(nfh_dev_model_inst.log[0], 10'h0a5, "data byte")
  endtask
  initial begin
    #2000000;
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    writeEnable <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_single();
    t_read();
    t_erase();
    t_wp();
    t_prog();
    summarize();
  end
endmodule
`default_nettype wire
